// File: srso_pkg.sv
// shared constants and carrier types of the reset-status and options block
// assumes a single 100 MHz core clock and a 32-bit APB master
`default_nettype none
package srso_pkg;
    // register byte offsets on the APB
    localparam logic [7:0] OFS_RESET_FLAGS   = 8'h00;
    localparam logic [7:0] OFS_SYS_OPTIONS   = 8'h04;
    localparam logic [7:0] OFS_CLKOUT_CTRL   = 8'h08;
    localparam logic [7:0] OFS_DEBUG_FORCE   = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STATUS    = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK      = 8'h14;

    // reset_source_flags bit positions
    localparam int BIT_POWER_ON     = 7;
    localparam int BIT_PIN          = 6;
    localparam int BIT_WATCHDOG     = 5;
    localparam int BIT_ILLEGAL_OP   = 4;
    localparam int BIT_CLOCK_GEN    = 2;
    localparam int BIT_LOW_VOLTAGE  = 1;

    // system_options bit positions
    localparam int BIT_WD_ENABLE    = 7;
    localparam int BIT_WD_TIMEOUT   = 6;
    localparam int BIT_HALT_ENABLE  = 5;
    localparam logic [7:0] OPTIONS_MASK = 8'he0;

    // clock_output_control fields
    localparam int BIT_CLKOUT_EN    = 4;
    localparam int DIV_LSB          = 0;
    localparam int DIV_W            = 3;
    localparam logic [7:0] CLKOUT_MASK = 8'h17;

    // debug_force_reset_register field
    localparam int BIT_DEBUG_FORCE  = 0;

    // interrupt status and mask bits
    localparam int IRQ_W            = 3;
    localparam int IRQ_WD_RESTART   = 0;
    localparam int IRQ_SYS_RESET    = 1;
    localparam int IRQ_HALT         = 2;

    // reset values
    localparam logic [7:0] FLAGS_POWER_ON_VALUE = 8'h82;
    localparam logic [7:0] OPTIONS_RESET_VALUE  = 8'hc0;
    localparam logic [7:0] CLKOUT_RESET_VALUE   = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET_VALUE = 3'h0;

    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } srso_apb_req_type;

    // apb answer to the master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } srso_apb_resp_type;

    // reset and instruction sources seen by the block
    typedef struct packed {
        logic reset_pin_n;          // external reset pin, asynchronous
        logic low_voltage_detect;   // supply monitor, asynchronous
        logic watchdog_timeout;     // pulse from the watchdog counter
        logic illegal_opcode_exec;  // core tried an unimplemented opcode
        logic halt_exec;            // core executes the halt instruction
        logic background_exec;      // core executes enter-background
        logic background_mode_enable;
        logic clock_generator_fault;
    } srso_sources_type;
endpackage : srso_pkg
`default_nettype wire

// File: srso_clkout_div.sv
// divided bus-clock output for the shared port pin
// assumes enable and divisor come from registers on the same clock
`default_nettype none
module srso_clkout_div
    import srso_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic             enable,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  pin_out,
    output logic                  pin_oe
);
    typedef struct packed {
        logic [DIV_W-1:0] count;
        logic             level;
        logic             oe;
    } srso_div_state_type;

    srso_div_state_type state_reg;
    srso_div_state_type state_next;

    // half period is divisor cycles, so the full period is twice that
    always_comb begin
        state_next    = state_reg;
        state_next.oe = enable;                                      // R14
        if (!enable || divisor == 3'h0) begin
            state_next.count = 3'h0;
            state_next.level = 1'b0;                                 // R16
        end else if (state_reg.count >= divisor - 3'h1) begin
            // >= also catches a divisor lowered below the running count
            state_next.count = 3'h0;
            state_next.level = ~state_reg.level;                     // R15
        end else begin
            state_next.count = state_reg.count + 3'h1;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pin_out = state_reg.level;
    assign pin_oe  = state_reg.oe;
endmodule : srso_clkout_div
`default_nettype wire

// File: srso_system_ctrl.sv
// reset-source flags, write-once system options and clock output control
// assumes resetn is the power-on reset; every later reset is requested by
// this block on sys_reset and handled synchronously inside it
//
// Summary of operation
// R01: a debug-forced reset leaves every reset-source flag cleared
// R02: any write to the flags address restarts the watchdog, flags stay
// R03: power-on sets power-on and low-voltage flags, clears the others
// R04: low-voltage reset keeps power-on, sets low-voltage, clears the rest
// R05: other resets set flags of active sources, clear all else
// R06: bit 6 shows a reset from the low reset pin
// R07: bit 5 shows a watchdog reset; none while watchdog disabled
// R08: an illegal opcode forces a reset and sets bit 4
// R09: enter-background is illegal while background mode is disabled
// R10: halt with halt disabled forces an illegal-opcode reset
// R11: watchdog enable in bit 7, write-once, resets to one
// R12: watchdog timeout select in bit 6, write-once, resets to one
// R13: halt enable in bit 5, write-once, resets to zero
// R14: clock-output enable in bit 4 drives the divided clock on the pin
// R15: output frequency is bus clock over twice the divider field
// R16: divider zero with output enabled drives the pin low
// R17: write-once options take only the first write after a reset
`default_nettype none
module srso_system_ctrl
    import srso_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire srso_apb_req_type  apb_req,
    output srso_apb_resp_type      apb_resp,
    input  wire srso_sources_type  sources,
    output logic                   sys_reset,
    output logic                   watchdog_restart,
    output logic                   watchdog_enable,
    output logic                   watchdog_timeout_select,
    output logic                   halt_granted,
    output logic                   shared_port_pin_out,
    output logic                   shared_port_pin_oe,
    output logic                   irq
);
    typedef struct packed {
        logic [1:0]       sync_a;       // first stage: pin_n, low voltage
        logic [1:0]       sync_b;       // second stage, the only one read
        logic [7:0]       flags;
        logic [7:0]       options;
        logic             opt_locked;
        logic [7:0]       clk_ctrl;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0]      prdata;
        logic             sys_reset;
        logic             wd_restart;
        logic             halt_grant;
    } srso_state_type;

    srso_state_type state_reg;
    srso_state_type state_next;

    // true for every address that holds a register
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == OFS_RESET_FLAGS) || (addr == OFS_SYS_OPTIONS) ||
                    (addr == OFS_CLKOUT_CTRL) || (addr == OFS_DEBUG_FORCE) ||
                    (addr == OFS_IRQ_STATUS)  || (addr == OFS_IRQ_MASK);
    endfunction : is_mapped

    // read multiplexer; narrow registers sit in the low bits
    function automatic logic [31:0] read_value(input logic [7:0] addr, input srso_state_type s);
        read_value = 32'h0000_0000;
        unique case (addr)
            OFS_RESET_FLAGS: read_value = {24'h000000, s.flags};
            OFS_SYS_OPTIONS: read_value = {24'h000000, s.options};        // R17
            OFS_CLKOUT_CTRL: read_value = {24'h000000, s.clk_ctrl};
            OFS_IRQ_STATUS:  read_value = {29'h00000000, s.irq_status};
            OFS_IRQ_MASK:    read_value = {29'h00000000, s.irq_mask};
            default:         read_value = 32'h0000_0000;
        endcase
    endfunction : read_value

    logic             setup_phase;
    logic             access_phase;
    logic             wr_access;
    logic             pin_reset;
    logic             lv_reset;
    logic             debug_force;
    logic             wd_reset;
    logic             illegal_opcode_flag_reset;
    logic             any_reset;
    logic [IRQ_W-1:0] irq_events;

    // bus phases
    assign setup_phase  = apb_req.psel && !apb_req.penable;
    assign access_phase = apb_req.psel && apb_req.penable;
    assign wr_access    = access_phase && apb_req.pwrite && is_mapped(apb_req.paddr);

    // reset sources, all evaluated on synchronised or same-clock signals
    assign pin_reset   = !state_reg.sync_b[1];                                  // R06
    assign lv_reset    = state_reg.sync_b[0];
    assign debug_force = wr_access && (apb_req.paddr == OFS_DEBUG_FORCE) &&
                         apb_req.pwdata[BIT_DEBUG_FORCE];
    assign wd_reset    = sources.watchdog_timeout && state_reg.options[BIT_WD_ENABLE]; // R07
    assign illegal_opcode_flag_reset  = sources.illegal_opcode_exec ||                          // R08
                         (sources.background_exec && !sources.background_mode_enable) || // R09
                         (sources.halt_exec && !state_reg.options[BIT_HALT_ENABLE]);    // R10
    assign any_reset   = pin_reset || lv_reset || debug_force || wd_reset ||
                         illegal_opcode_flag_reset || sources.clock_generator_fault;

    // events for the interrupt status register
    always_comb begin
        irq_events                 = '0;
        irq_events[IRQ_WD_RESTART] = wr_access && (apb_req.paddr == OFS_RESET_FLAGS);
        irq_events[IRQ_SYS_RESET]  = any_reset && !state_reg.sys_reset;
        irq_events[IRQ_HALT]       = sources.halt_exec && state_reg.options[BIT_HALT_ENABLE];
    end

    // next-state logic for the whole block
    always_comb begin
        state_next            = state_reg;
        state_next.sync_a     = {sources.reset_pin_n, sources.low_voltage_detect};
        state_next.sync_b     = state_reg.sync_a;
        state_next.wd_restart = 1'b0;
        state_next.halt_grant = sources.halt_exec && state_reg.options[BIT_HALT_ENABLE];
        state_next.sys_reset  = any_reset;

        // read data is captured in setup so it is steady through access
        if (setup_phase && !apb_req.pwrite) begin
            state_next.prdata = read_value(apb_req.paddr, state_reg);
        end

        // register writes take effect at the access edge
        if (wr_access) begin
            unique case (apb_req.paddr)
                OFS_RESET_FLAGS: begin
                    state_next.wd_restart = 1'b1;                            // R02
                end
                OFS_SYS_OPTIONS: begin
                    if (!state_reg.opt_locked) begin
                        state_next.options    = apb_req.pwdata[7:0] & OPTIONS_MASK; // R11 R12 R13
                        state_next.opt_locked = 1'b1;                        // R17
                    end
                end
                OFS_CLKOUT_CTRL: begin
                    state_next.clk_ctrl = apb_req.pwdata[7:0] & CLKOUT_MASK; // R14 R15
                end
                OFS_IRQ_MASK: begin
                    state_next.irq_mask = apb_req.pwdata[IRQ_W-1:0];
                end
                OFS_IRQ_STATUS: begin
                    state_next.irq_status = state_reg.irq_status & ~apb_req.pwdata[IRQ_W-1:0];
                end
                default: begin
                    // debug force handled below; its read-back is zero
                end
            endcase
        end

        // a new event wins over a clear in the same cycle
        state_next.irq_status = state_next.irq_status | irq_events;

        // system reset: options and clock output return to defaults
        if (any_reset) begin
            state_next.options    = OPTIONS_RESET_VALUE;                     // R11 R12 R13
            state_next.opt_locked = 1'b0;                                    // R17
            state_next.clk_ctrl   = CLKOUT_RESET_VALUE;
            state_next.halt_grant = 1'b0;
            if (lv_reset) begin
                // low voltage dominates; power-on flag is left as it was
                state_next.flags                  = 8'h00;
                state_next.flags[BIT_POWER_ON]    = state_reg.flags[BIT_POWER_ON]; // R04
                state_next.flags[BIT_LOW_VOLTAGE] = 1'b1;                    // R04
            end else if (debug_force) begin
                state_next.flags = 8'h00;                                    // R01
            end else begin
                // a source held over several cycles keeps being recorded
                state_next.flags                 = 8'h00;                    // R05
                state_next.flags[BIT_PIN]        = pin_reset;                // R06
                state_next.flags[BIT_WATCHDOG]   = wd_reset;                 // R07
                state_next.flags[BIT_ILLEGAL_OP] = illegal_opcode_flag_reset;               // R08
                state_next.flags[BIT_CLOCK_GEN]  = sources.clock_generator_fault;
            end
        end
    end

    // state register; power-on values come from constants only
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg            <= '0;
            state_reg.sync_a     <= 2'h2;   // pin idles high
            state_reg.sync_b     <= 2'h2;
            state_reg.flags      <= FLAGS_POWER_ON_VALUE;                    // R03
            state_reg.options    <= OPTIONS_RESET_VALUE;
            state_reg.clk_ctrl   <= CLKOUT_RESET_VALUE;
            state_reg.irq_status <= IRQ_RESET_VALUE;
            state_reg.irq_mask   <= IRQ_RESET_VALUE;
        end else begin
            state_reg <= state_next;
        end
    end

    // divided clock onto the shared pin
    srso_clkout_div u_clkout_div (
        .core_clk (core_clk),
        .resetn   (resetn),
        .enable   (state_reg.clk_ctrl[BIT_CLKOUT_EN]),
        .divisor  (state_reg.clk_ctrl[DIV_LSB +: DIV_W]),
        .pin_out  (shared_port_pin_out),
        .pin_oe   (shared_port_pin_oe)
    );

    // zero-wait slave; unmapped addresses answer with an error
    always_comb begin
        apb_resp         = '0;
        apb_resp.pready  = 1'b1;
        apb_resp.pslverr = access_phase && !is_mapped(apb_req.paddr);
        apb_resp.prdata  = state_reg.prdata;
    end

    // outputs straight from the state register
    assign sys_reset               = state_reg.sys_reset;
    assign watchdog_restart        = state_reg.wd_restart;
    assign watchdog_enable         = state_reg.options[BIT_WD_ENABLE];       // R11
    assign watchdog_timeout_select = state_reg.options[BIT_WD_TIMEOUT];      // R12
    assign halt_granted            = state_reg.halt_grant;                   // R13
    assign irq                     = |(state_reg.irq_status & state_reg.irq_mask);
endmodule : srso_system_ctrl
`default_nettype wire

// File: srso_system_ctrl_checker.sv
// concurrent checks on the ports of the reset-status and options block
// assumes one core clock domain; bound from the bench top file
`default_nettype none
module srso_system_ctrl_checker
    import srso_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              resetn,
    input wire srso_apb_req_type  apb_req,
    input wire srso_apb_resp_type apb_resp,
    input wire srso_sources_type  sources,
    input wire logic              sys_reset,
    input wire logic              watchdog_restart,
    input wire logic              watchdog_enable,
    input wire logic              watchdog_timeout_select,
    input wire logic              halt_granted,
    input wire logic              shared_port_pin_out,
    input wire logic              shared_port_pin_oe,
    input wire logic              irq
);
    timeunit 1ns;
    timeprecision 100ps;

    logic wr_flags;
    logic wr_force;

    // completed writes decoded once so that the properties stay short
    assign wr_flags = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == OFS_RESET_FLAGS;
    assign wr_force = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == OFS_DEBUG_FORCE;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    chk_restart_pulse: assert property (wr_flags |=> watchdog_restart)
        else $error("watchdog restart missing after flags write");
    chk_restart_cause: assert property (watchdog_restart |-> $past(wr_flags))
        else $error("watchdog restart without a flags write");
    chk_force_reset: assert property (wr_force && apb_req.pwdata[0] |-> ##[1:2] sys_reset)
        else $error("debug force write did not reset");
    chk_illegal_opcode_flag_reset: assert property (sources.illegal_opcode_exec |=> sys_reset)
        else $error("illegal opcode did not reset");
    chk_enter_background_instruction_reset: assert property (sources.background_exec && !sources.background_mode_enable |=> sys_reset)
        else $error("background entry while disabled did not reset");
    chk_halt_path: assert property (sources.halt_exec |=> halt_granted || sys_reset)
        else $error("halt neither granted nor reset");
    chk_halt_cause: assert property (halt_granted |-> $past(sources.halt_exec))
        else $error("halt granted without a halt instruction");
    chk_wd_reset: assert property (sources.watchdog_timeout && watchdog_enable |=> sys_reset)
        else $error("enabled watchdog timeout did not reset");
    chk_opts_default: assert property (sys_reset |-> watchdog_enable && watchdog_timeout_select)
        else $error("options not at defaults during reset");
    chk_clkout_idle: assert property (!shared_port_pin_oe && !$past(shared_port_pin_oe)
        |-> !shared_port_pin_out)
        else $error("clock pin active while output disabled");
    chk_apb_ready: assert property (apb_req.psel && apb_req.penable |-> apb_resp.pready)
        else $error("access phase without ready");
    chk_apb_unmapped: assert property (apb_req.psel && apb_req.penable && apb_req.paddr > OFS_IRQ_MASK
        |-> apb_resp.pslverr)
        else $error("unmapped access without error");
endmodule : srso_system_ctrl_checker
`default_nettype wire

// File: tb_top.sv
// self-checking bench of the reset-status and options block over apb
// assumes the checker module is compiled alongside and bound below
`default_nettype none
module tb_top
    import srso_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              core_clk = 1'b0;
    logic              resetn;
    srso_apb_req_type  apb_req;
    srso_apb_resp_type apb_resp;
    srso_sources_type  sources;
    logic              sys_reset;
    logic              watchdog_restart;
    logic              watchdog_enable;
    logic              watchdog_timeout_select;
    logic              halt_granted;
    logic              shared_port_pin_out;
    logic              shared_port_pin_oe;
    logic              irq;
    int                err_count;
    int                n_checks;
    int                seed;
    int                hi;
    int                lo;
    logic [31:0]       exp_q[$];
    logic [7:0]        src_tab[10];
    logic [7:0]        flag_tab[10];

    srso_system_ctrl dut (.core_clk(core_clk), .resetn(resetn), .apb_req(apb_req), .apb_resp(apb_resp),
        .sources(sources), .sys_reset(sys_reset), .watchdog_restart(watchdog_restart),
        .watchdog_enable(watchdog_enable), .watchdog_timeout_select(watchdog_timeout_select),
        .halt_granted(halt_granted), .shared_port_pin_out(shared_port_pin_out),
        .shared_port_pin_oe(shared_port_pin_oe), .irq(irq));

    // core clock, 10 ns period
    always #5 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            err_count++;
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // one apb transfer; entered just after a rising edge, leaves one idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do @(posedge core_clk); while (apb_resp.pready !== 1'b1);
        apb_req <= '0;
        @(posedge core_clk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // hold a source pattern long enough to pass the pin synchroniser
    task automatic pulse(input logic [7:0] s);
        sources <= s;
        repeat (5) @(posedge core_clk);
        sources <= 8'h80;
        repeat (8) @(posedge core_clk);
    endtask : pulse

    // phase lengths of the clock pin, sampled on falling edges to avoid races
    task automatic meas(output int h, output int l);
        int n;
        n = 0;
        h = 0;
        l = 0;
        @(negedge core_clk);
        while (shared_port_pin_out !== 1'b0 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        while (shared_port_pin_out !== 1'b1 && n < 80) begin
            @(negedge core_clk);
            n++;
        end
        while (shared_port_pin_out === 1'b1 && h < 40) begin
            @(negedge core_clk);
            h++;
        end
        while (shared_port_pin_out === 1'b0 && l < 40) begin
            @(negedge core_clk);
            l++;
        end
        @(posedge core_clk);
    endtask : meas

    // read data is compared at the access edge with the oldest note
    always @(posedge core_clk) begin
        if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_resp.pready && exp_q.size() > 0) begin
            check(apb_resp.prdata, exp_q.pop_front());
        end
    end

    // cuts a hang short well beyond the expected run length
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        complete_run();
    end

    // main sequence
    initial begin
        resetn = 1'b0;
        apb_req = '0;
        sources = 8'h80;
        err_count = 0;
        n_checks = 0;
        seed = 32'h412f;
        src_tab = '{8'hc0, 8'ha0, 8'h90, 8'h84, 8'h88, 8'h81, 8'h86, 8'h00, 8'hb1, 8'hc0};
        flag_tab = '{8'h82, 8'h20, 8'h10, 8'h10, 8'h10, 8'h04, 8'h04, 8'h40, 8'h34, 8'h02};
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        rd(OFS_RESET_FLAGS, FLAGS_POWER_ON_VALUE);
        rd(OFS_SYS_OPTIONS, 8'hc0);
        rd(OFS_CLKOUT_CTRL, 8'h00);
        rd(8'h20, 8'h00);
        // restart write with random data leaves the flags alone
        apb(1'b1, OFS_RESET_FLAGS, $random(seed));
        rd(OFS_RESET_FLAGS, 8'h82);
        // only the first options write counts
        apb(1'b1, OFS_SYS_OPTIONS, 32'h20);
        apb(1'b1, OFS_SYS_OPTIONS, $random(seed));
        rd(OFS_SYS_OPTIONS, 8'h20);
        check({31'h0, watchdog_enable}, 32'h0);
        check({31'h0, watchdog_timeout_select}, 32'h0);
        pulse(8'ha0);
        rd(OFS_RESET_FLAGS, 8'h82);
        sources <= 8'h88;
        @(posedge core_clk);
        sources <= 8'h80;
        #1 check({31'h0, halt_granted}, 32'h1);
        @(posedge core_clk);
        // every reset cause except debug force in turn; the last low-voltage one sees power-on clear
        for (int i = 0; i < 10; i++) begin
            pulse(src_tab[i]);
            rd(OFS_RESET_FLAGS, flag_tab[i]);
        end
        apb(1'b1, OFS_DEBUG_FORCE, 32'h1);
        repeat (4) @(posedge core_clk);
        rd(OFS_RESET_FLAGS, 8'h00);
        rd(OFS_SYS_OPTIONS, OPTIONS_RESET_VALUE);
        // a system reset unlocks the options for one more first write
        apb(1'b1, OFS_SYS_OPTIONS, 32'h0);
        rd(OFS_SYS_OPTIONS, 8'h00);
        // divider sweep; settle time lets the old period run out
        for (int d = 1; d < 8; d++) begin
            apb(1'b1, OFS_CLKOUT_CTRL, 32'h10 | d);
            repeat (16) @(posedge core_clk);
            meas(hi, lo);
            check(hi, d);
            check(lo, d);
        end
        apb(1'b1, OFS_CLKOUT_CTRL, 32'hff);
        rd(OFS_CLKOUT_CTRL, 8'h17);
        apb(1'b1, OFS_CLKOUT_CTRL, 32'h10);
        meas(hi, lo);
        check(hi, 32'h0);
        check({31'h0, shared_port_pin_oe}, 32'h1);
        apb(1'b1, OFS_CLKOUT_CTRL, 32'h03);
        meas(hi, lo);
        check(hi, 32'h0);
        check({31'h0, shared_port_pin_oe}, 32'h0);
        // interrupt: all three events seen so far, then mask and clear
        rd(OFS_IRQ_STATUS, 8'h07);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_STATUS, 32'h7);
        check({31'h0, irq}, 32'h0);
        rd(OFS_IRQ_STATUS, 8'h00);
        apb(1'b1, OFS_RESET_FLAGS, 32'h0);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h1);
        rd(OFS_IRQ_MASK, 8'h01);
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        check({31'h0, irq}, 32'h0);
        @(posedge core_clk);
        complete_run();
    end
endmodule : tb_top

bind srso_system_ctrl srso_system_ctrl_checker u_chk (.core_clk(core_clk), .resetn(resetn), .apb_req(apb_req),
    .apb_resp(apb_resp), .sources(sources), .sys_reset(sys_reset), .watchdog_restart(watchdog_restart),
    .watchdog_enable(watchdog_enable), .watchdog_timeout_select(watchdog_timeout_select),
    .halt_granted(halt_granted), .shared_port_pin_out(shared_port_pin_out),
    .shared_port_pin_oe(shared_port_pin_oe), .irq(irq));
`default_nettype wire
